//--- hdl/break_match_pkg.sv
// Constants shared by the breakpoint logic: register offsets, bit positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package break_match_pkg;
  localparam int ADDR_W = 16;
  localparam int AXI_AW = 16;
  // Printed offsets are not all multiples of four, so they are indices; byte address is four times the index.
  localparam logic [15:0] IDX_SYS_BREAK_STATUS  = 16'hFE00;
  localparam logic [15:0] IDX_SYS_BREAK_FLAG    = 16'hFE03;
  localparam logic [15:0] IDX_BREAK_ADDR_HIGH   = 16'hFE0C;
  localparam logic [15:0] IDX_BREAK_ADDR_LOW    = 16'hFE0D;
  localparam logic [15:0] IDX_BREAK_CTRL_STATUS = 16'hFE0E;
  localparam logic [15:0] IDX_IRQ_STATUS        = 16'hFE10;
  localparam logic [15:0] IDX_IRQ_MASK          = 16'hFE11;
  localparam int BIT_MATCH_ENABLE = 7;
  localparam int BIT_ACTIVE       = 6;
  localparam int BIT_WAIT_FLAG    = 1;
  localparam int BIT_FIXED_ONE    = 4;
  localparam int BIT_CLEAR_ENABLE = 7;
  localparam int IRQ_W            = 2;
  localparam int IRQ_MATCH        = 0;
  localparam int IRQ_WAKE         = 1;
  localparam logic [7:0]  STATUS_FIXED  = 8'h10;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    BRK_IDLE  = 2'b00,
    BRK_TAKEN = 2'b01,
    BRK_HELD  = 2'b11
  } brk_state_e;
  function automatic logic [15:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx[13:0], 2'b00};
  endfunction
endpackage

//--- hdl/addr_comparator.sv
// Registered 16-bit equality compare of the CPU program address with the break address.
// Assumes the address and its qualifier are synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module addr_comparator #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] cpu_addr,
  input  wire logic             cpu_addr_valid,
  input  wire logic [WIDTH-1:0] break_addr,
  input  wire logic             enable,
  output logic                  hit
);
  wire equal_now = cpu_addr_valid && enable && (cpu_addr == break_addr);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hit <= 1'b0;
    end else begin
      hit <= equal_now;
    end
  end
endmodule
`default_nettype wire

//--- hdl/axil_wr_capture.sv
// Captures AXI4-Lite write address and data in either order and presents one write when both are held.
// Assumes the master keeps each valid high until it is taken.
`timescale 1ns/1ns
`default_nettype none
module axil_wr_capture #(
  parameter int AW = 16
) (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic          done,
  output logic               pending,
  output logic [AW-1:0]      addr,
  output logic [31:0]        data,
  output logic [3:0]         strb
);
  logic have_a;
  logic have_d;
  // Each ready comes from a flip-flop that holds the inverse of the next held state.
  // Nothing is captured unless its ready is high, so no item is taken twice.
  wire next_have_a = !done && (have_a || (awvalid && awready));
  wire next_have_d = !done && (have_d || (wvalid && wready));
  assign pending = have_a && have_d;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !next_have_a;
      wready  <= !next_have_d;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      have_a <= 1'b0;
      have_d <= 1'b0;
      addr   <= '0;
      data   <= '0;
      strb   <= '0;
    end else if (done) begin
      have_a <= 1'b0;
      have_d <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        have_a <= 1'b1;
        addr   <= awaddr;
      end
      if (wvalid && wready) begin
        have_d <= 1'b1;
        data   <= wdata;
        strb   <= wstrb;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/break_address_match.sv
// Breakpoint logic beside the CPU core, with its registers behind an AXI4-Lite slave.
// Assumes the CPU address, mode flags and return strobe are synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module break_address_match
  import break_match_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         resetn,
  input  wire logic [break_match_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [break_match_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [break_match_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                         cpu_addr_valid,
  input  wire logic                         cpu_return_from_interrupt,
  input  wire logic                         cpu_in_wait,
  input  wire logic                         cpu_in_stop,
  input  wire logic                         test_high_voltage,
  output logic                              break_request,
  output logic                              timer_freeze,
  output logic                              watchdog_disable,
  output logic                              status_clear_allowed,
  output logic                              wake_request,
  output logic                              irq
);
  brk_state_e state;
  brk_state_e next_state;
  logic [7:0] break_addr_high;
  logic [7:0] break_addr_low;
  logic       break_match_enable;
  logic       break_active;
  logic       break_wait_flag;
  logic       status_clear_in_break_enable;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic       match_hit;
  logic       wr_pending;
  logic [AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_done;

  // The comparator does not look at the wait or stop inputs, so it keeps running in wait mode.
  addr_comparator #(.WIDTH(ADDR_W)) u_cmp (
    .clock          (clock),
    .resetn         (resetn),
    .cpu_addr       (cpu_addr),
    .cpu_addr_valid (cpu_addr_valid),
    .break_addr     ({break_addr_high, break_addr_low}),
    .enable         (break_match_enable),
    .hit            (match_hit)
  );

  axil_wr_capture #(.AW(AXI_AW)) u_wr (
    .clock   (clock),
    .resetn  (resetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .done    (wr_done),
    .pending (wr_pending),
    .addr    (wr_addr),
    .data    (wr_data),
    .strb    (wr_strb)
  );

  // One list of mapped registers serves both the write and the read response.
  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    is_mapped = (a == byte_addr(IDX_BREAK_CTRL_STATUS)) || (a == byte_addr(IDX_BREAK_ADDR_HIGH))
             || (a == byte_addr(IDX_BREAK_ADDR_LOW)) || (a == byte_addr(IDX_SYS_BREAK_STATUS))
             || (a == byte_addr(IDX_SYS_BREAK_FLAG)) || (a == byte_addr(IDX_IRQ_STATUS))
             || (a == byte_addr(IDX_IRQ_MASK));
  endfunction

  // Write decode; only byte lane 0 carries register data.
  // A held write waits while its response is unanswered, so only one response is ever outstanding.
  wire wr_fire  = wr_pending && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire [7:0] wb = wr_data[7:0];
  wire wr_ctrl  = wr_lane0 && (wr_addr == byte_addr(IDX_BREAK_CTRL_STATUS));
  wire wr_high  = wr_lane0 && (wr_addr == byte_addr(IDX_BREAK_ADDR_HIGH));
  wire wr_low   = wr_lane0 && (wr_addr == byte_addr(IDX_BREAK_ADDR_LOW));
  wire wr_stat  = wr_lane0 && (wr_addr == byte_addr(IDX_SYS_BREAK_STATUS));
  wire wr_flag  = wr_lane0 && (wr_addr == byte_addr(IDX_SYS_BREAK_FLAG));
  wire wr_istat = wr_lane0 && (wr_addr == byte_addr(IDX_IRQ_STATUS));
  wire wr_imask = wr_lane0 && (wr_addr == byte_addr(IDX_IRQ_MASK));
  wire wr_known = is_mapped(wr_addr);
  assign wr_done = wr_fire;

  // A software write of one to the active bit raises a break like a match does.
  wire sw_break   = wr_ctrl && wb[BIT_ACTIVE];
  wire break_evt  = match_hit || sw_break;
  // A break while waiting or stopped is the wake-up that the wait flag records.
  wire wake_evt   = break_evt && (cpu_in_wait || cpu_in_stop);

  // Break state machine: a request is issued, then held until the return from interrupt.
  always_comb begin
    next_state = state;
    case (state)
      BRK_IDLE: begin
        if (break_evt) begin
          next_state = BRK_TAKEN;
        end
      end
      BRK_TAKEN: begin
        next_state = BRK_HELD;
      end
      BRK_HELD: begin
        if (cpu_return_from_interrupt) begin
          next_state = BRK_IDLE;
        end
      end
      default: begin
        next_state = BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= BRK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Control register: enable is plain read/write; active is set by hardware, cleared by writing zero.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_match_enable <= 1'b0;
    end else if (wr_ctrl) begin
      break_match_enable <= wb[BIT_MATCH_ENABLE];
    end
  end

  // A break event wins over a clearing write in the same cycle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_active <= 1'b0;
    end else if (break_evt) begin
      break_active <= 1'b1;
    end else if (wr_ctrl) begin
      break_active <= wb[BIT_ACTIVE];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_addr_high <= RESET_BYTE;
    end else if (wr_high) begin
      break_addr_high <= wb;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_addr_low <= RESET_BYTE;
    end else if (wr_low) begin
      break_addr_low <= wb;
    end
  end

  // Wait flag: set wins over a clearing write in the same cycle; writing one leaves it alone.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_wait_flag <= 1'b0;
    end else if (wake_evt) begin
      break_wait_flag <= 1'b1;
    end else if (wr_stat && !wb[BIT_WAIT_FLAG]) begin
      break_wait_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_clear_in_break_enable <= 1'b0;
    end else if (wr_flag) begin
      status_clear_in_break_enable <= wb[BIT_CLEAR_ENABLE];
    end
  end

  // Interrupt status is sticky and cleared by writing one; a new event wins over the clear.
  wire [IRQ_W-1:0] irq_evt = {wake_evt, match_hit};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= irq_evt | (irq_status & ~(wr_istat ? wb[IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= '0;
    end else if (wr_imask) begin
      irq_mask <= wb[IRQ_W-1:0];
    end
  end

  // Side-band outputs, each from a flip-flop of its own so that every output of the block is registered.
  wire in_break = (next_state != BRK_IDLE);

  // The CPU decides when to take the request: at the end of the current instruction or at once.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_request <= 1'b0;
    end else begin
      break_request <= (next_state == BRK_TAKEN);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_freeze <= 1'b0;
    end else begin
      timer_freeze <= in_break;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      watchdog_disable <= 1'b0;
    end else begin
      watchdog_disable <= in_break && test_high_voltage;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_clear_allowed <= 1'b0;
    end else begin
      status_clear_allowed <= !in_break || status_clear_in_break_enable;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= wake_evt && cpu_in_stop;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read path. Unmapped addresses read zero and answer SLVERR,
  // so software can tell a wrong offset from a cleared register.
  wire [15:0] ra = s_axi_araddr;
  wire [7:0] rd_ctrl = {break_match_enable, break_active, 6'h00};
  wire [7:0] rd_stat = STATUS_FIXED | {6'h00, break_wait_flag, 1'b0};
  wire [7:0] rd_flag = {status_clear_in_break_enable, 7'h00};
  wire rd_known;
  wire [7:0] rd_byte;
  assign rd_byte = (ra == byte_addr(IDX_BREAK_CTRL_STATUS)) ? rd_ctrl :
                   (ra == byte_addr(IDX_BREAK_ADDR_HIGH))   ? break_addr_high :
                   (ra == byte_addr(IDX_BREAK_ADDR_LOW))    ? break_addr_low :
                   (ra == byte_addr(IDX_SYS_BREAK_STATUS))  ? rd_stat :
                   (ra == byte_addr(IDX_SYS_BREAK_FLAG))    ? rd_flag :
                   (ra == byte_addr(IDX_IRQ_STATUS))        ? {6'h00, irq_status} :
                   (ra == byte_addr(IDX_IRQ_MASK))          ? {6'h00, irq_mask} : 8'h00;
  assign rd_known = is_mapped(ra);
  wire rd_take = s_axi_arvalid && s_axi_arready;

  // Read responses are one at a time: arready drops while a read data beat waits.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/break_match_assertions.sv
// Concurrent checks on the ports of break_address_match.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module break_match_assertions (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        cpu_return_from_interrupt,
  input wire logic        test_high_voltage,
  input wire logic        break_request,
  input wire logic        timer_freeze,
  input wire logic        watchdog_disable,
  input wire logic        status_clear_allowed,
  input wire logic        wake_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence write_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  req_one_cycle_a: assert property (break_request |=> !break_request)
    else $error("break request wider than one cycle");
  freeze_with_req_a: assert property (break_request |-> timer_freeze)
    else $error("timer not frozen with break request");
  freeze_cause_a: assert property ($rose(timer_freeze) |-> break_request)
    else $error("timer frozen without break request");
  no_rebreak_a: assert property (break_request |-> !$past(timer_freeze))
    else $error("second break while break in effect");
  return_ends_a: assert property (cpu_return_from_interrupt && timer_freeze |-> ##[1:3] !timer_freeze)
    else $error("timer still frozen after return");
  wdog_gate_a: assert property (watchdog_disable |-> timer_freeze && $past(test_high_voltage))
    else $error("watchdog disabled outside break with test voltage");
  clear_free_a: assert property (!timer_freeze && !$past(timer_freeze) && $past(resetn) |-> status_clear_allowed)
    else $error("flag clearing blocked outside break");
  wake_in_break_a: assert property (wake_request |-> timer_freeze)
    else $error("wake request without break");
  read_answer_a: assert property (read_taken_s |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer late or upper bits set");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  write_answer_a: assert property (write_taken_s |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
endmodule
bind break_address_match break_match_assertions chk_u (.*);
`default_nettype wire

//--- tb/cpu_core_model.sv
// Behavioural CPU core that fetches program addresses and takes breaks.
// Assumes the bench starts fetching with run and ends a break with leave_break.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        run,
  input  wire logic [15:0] start_addr,
  input  wire logic        leave_break,
  input  wire logic        break_request,
  output logic [15:0]      cpu_addr,
  output logic             cpu_addr_valid,
  output logic             cpu_return_from_interrupt,
  output logic             in_break
);
  logic [15:0] pc;
  logic [15:0] resume_pc;
  // An idle bus shows the inverse of pc, which run low loads with start_addr, so a stale match cannot pass.
  assign cpu_addr = cpu_addr_valid ? pc : ~pc;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc <= 16'h0000;
      resume_pc <= 16'h0000;
      in_break <= 1'b0;
      cpu_addr_valid <= 1'b0;
      cpu_return_from_interrupt <= 1'b0;
    end else begin
      cpu_return_from_interrupt <= 1'b0;
      cpu_addr_valid <= run || in_break;
      if (break_request && !in_break) begin
        in_break <= 1'b1;
        resume_pc <= pc;
        pc <= 16'hFFFC;
      end else if (in_break && leave_break) begin
        in_break <= 1'b0;
        cpu_return_from_interrupt <= 1'b1;
        pc <= resume_pc + 16'h0001;
      end else if (!in_break) begin
        pc <= !run ? start_addr : (cpu_addr_valid ? pc + 16'h0001 : pc);
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/break_address_match_tb_top.sv
// Self-checking bench for break_address_match with a CPU core model on the break link.
// Assumes the package, design, checker and core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module break_address_match_tb_top;
  logic        clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_addr_valid, cpu_return_from_interrupt;
  logic        cpu_in_wait, cpu_in_stop, test_high_voltage, break_request, timer_freeze, watchdog_disable;
  logic        status_clear_allowed, wake_request, irq, run, leave_break, in_break;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] s_axi_awaddr, s_axi_araddr, cpu_addr, start_addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  int          bad_count, n_tests, brk_n, wake_n, n0;
  break_address_match dut_u (.*);
  cpu_core_model cpu_u (.clock(clock), .resetn(resetn), .run(run), .start_addr(start_addr),
    .leave_break(leave_break), .break_request(break_request), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_return_from_interrupt(cpu_return_from_interrupt), .in_break(in_break));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (break_request === 1'b1) brk_n <= brk_n + 1;
    if (wake_request === 1'b1) wake_n <= wake_n + 1;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic stall();
    bad_count++;
    $display("CHECK FAILED at %0t seen timeout expected answer", $time);
    conclude();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) stall();
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) stall();
    check(rd_val, exp);
  endtask
  task automatic wait_cnt(ref int cnt, input int from);
    int n;
    for (n = 0; n < 40 && cnt == from; n++) @(posedge clock);
    if (n == 40) stall();
  endtask
  // The core returns once asked; the bench waits for the freeze to lift.
  task automatic leave();
    int n;
    leave_break <= 1'b1;
    for (n = 0; n < 40 && timer_freeze !== 1'b0; n++) @(posedge clock);
    leave_break <= 1'b0;
    if (n == 40) stall();
  endtask
  task automatic reg_reset();
    logic [15:0] addr [5] = '{16'hF800, 16'hF80C, 16'hF830, 16'hF834, 16'hF838};
    for (int i = 0; i < 5; i++) begin
      rd(addr[i], (i == 0) ? 32'h10 : 32'h0);
    end
    rd(16'hF804, 32'h0);
    check({30'h0, rd_resp}, 32'h2);
    wr(16'hF804, 32'h0);
    check({30'h0, wr_resp}, 32'h2);
    $display("test reg_reset done");
  endtask
  task automatic reg_access();
    wr(16'hF830, 32'h12);
    wr(16'hF834, 32'h34);
    wr(16'hF80C, 32'hFF);
    check({30'h0, wr_resp}, 32'h0);
    rd(16'hF830, 32'h12);
    rd(16'hF834, 32'h34);
    rd(16'hF80C, 32'h80);
    $display("test reg_access done");
  endtask
  task automatic match_break();
    n0 = brk_n;
    wr(16'hF838, 32'h80);
    test_high_voltage <= 1'b1;
    run <= 1'b1;
    wait_cnt(brk_n, n0);
    check({31'h0, timer_freeze}, 32'h1);
    check({31'h0, watchdog_disable}, 32'h1);
    check({31'h0, status_clear_allowed}, 32'h1);
    wr(16'hF80C, 32'h0);
    rd(16'hF838, 32'hC0);
    check({31'h0, status_clear_allowed}, 32'h0);
    rd(16'hF840, 32'h1);
    check({31'h0, irq}, 32'h0);
    wr(16'hF844, 32'h1);
    rd(16'hF844, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(16'hF840, 32'h1);
    rd(16'hF840, 32'h0);
    check({31'h0, irq}, 32'h0);
    leave();
    run <= 1'b0;
    wr(16'hF838, 32'h80);
    rd(16'hF838, 32'h80);
    check({31'h0, status_clear_allowed}, 32'h1);
    $display("test match_break done");
  endtask
  task automatic no_match_soft();
    wr(16'hF838, 32'h0);
    n0 = brk_n;
    run <= 1'b1;
    repeat (20) @(posedge clock);
    run <= 1'b0;
    check(32'(brk_n), 32'(n0));
    wr(16'hF838, 32'h40);
    wait_cnt(brk_n, n0);
    rd(16'hF838, 32'h40);
    leave();
    wr(16'hF838, 32'h0);
    $display("test no_match_soft done");
  endtask
  task automatic wait_stop();
    cpu_in_wait <= 1'b1;
    n0 = brk_n;
    wr(16'hF838, 32'h80);
    run <= 1'b1;
    wait_cnt(brk_n, n0);
    run <= 1'b0;
    rd(16'hF800, 32'h12);
    wr(16'hF800, 32'hFF);
    rd(16'hF800, 32'h12);
    wr(16'hF800, 32'h0);
    rd(16'hF800, 32'h10);
    leave();
    cpu_in_wait <= 1'b0;
    cpu_in_stop <= 1'b1;
    n0 = wake_n;
    wr(16'hF838, 32'hC0);
    wait_cnt(wake_n, n0);
    rd(16'hF800, 32'h12);
    leave();
    cpu_in_stop <= 1'b0;
    $display("test wait_stop done");
  endtask
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_in_wait, cpu_in_stop, test_high_voltage, run, leave_break} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    start_addr = 16'h1230;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    reg_reset();
    reg_access();
    match_break();
    no_match_soft();
    wait_stop();
    conclude();
  end
endmodule
`default_nettype wire
